//--- pkg/limit_coeff_pkg.sv
// constants, types and helpers for the limit and coefficient register bank
//
// Behaviour
// - object thresholds hold signed 10-bit field in bits 15..6, half degree per count
// - die thresholds use the same signed 10-bit field, half degree per count
// - threshold bits 5..0 ignore writes and always read zero
// - object upper threshold at index 06h, resets to 7FC0h
// - object lower threshold at index 07h, resets to 8000h
// - die upper threshold at index 08h, resets to 7FC0h
// - die lower threshold at index 09h, resets to 8000h
// - coefficient contents drive the math engine operands directly
// - scale coefficient at 0Ah, unsigned 16-bit, resets to 260Eh
// - first-order offset coefficient at 0Bh, signed, resets to 0106h
// - second-order offset coefficient at 0Ch, signed, resets to FF9Bh
// - constant drift coefficient at 0Dh, signed, resets to FF3Ah
// - signed thresholds and coefficients are twos complement, bit 15 sign
// - object upper flag sets when object result exceeds upper threshold
// - object lower flag sets below lower threshold; off in comparator mode
// - die upper flag sets when die result exceeds upper threshold
// - die lower flag sets when die result drops below lower threshold; off in comparator mode
`default_nettype none
package limit_coeff_pkg;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [7:0] IDX_OBJ_UPPER = 8'h06;
    localparam logic [7:0] IDX_OBJ_LOWER = 8'h07;
    localparam logic [7:0] IDX_DIE_UPPER = 8'h08;
    localparam logic [7:0] IDX_DIE_LOWER = 8'h09;
    localparam logic [7:0] IDX_SCALE = 8'h0A;
    localparam logic [7:0] IDX_OFS_LIN = 8'h0B;
    localparam logic [7:0] IDX_OFS_QUAD = 8'h0C;
    localparam logic [7:0] IDX_DRIFT_CONST = 8'h0D;
    localparam logic [7:0] IDX_DRIFT_LIN = 8'h0E;
    localparam logic [7:0] IDX_DRIFT_QUAD = 8'h0F;
    localparam logic [7:0] IDX_POLY = 8'h10;
    localparam logic [7:0] IDX_TRANS_CONST = 8'h11;
    localparam logic [7:0] IDX_TRANS_SLOPE = 8'h12;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int THR_MSB = 15;
    localparam int THR_LSB = 6;
    localparam int THR_W = THR_MSB - THR_LSB + 1;
    localparam logic [15:0] POLY_MASK = 16'hFFF0;
    localparam logic [15:0] RST_OBJ_UPPER = 16'h7FC0;
    localparam logic [15:0] RST_OBJ_LOWER = 16'h8000;
    localparam logic [15:0] RST_DIE_UPPER = 16'h7FC0;
    localparam logic [15:0] RST_DIE_LOWER = 16'h8000;
    localparam logic [15:0] RST_SCALE = 16'h260E;
    localparam logic [15:0] RST_OFS_LIN = 16'h0106;
    localparam logic [15:0] RST_OFS_QUAD = 16'hFF9B;
    localparam logic [15:0] RST_DRIFT_CONST = 16'hFF3A;
    localparam logic [15:0] RST_DRIFT_LIN = 16'hFF71;
    localparam logic [15:0] RST_DRIFT_QUAD = 16'h0553;
    localparam logic [15:0] RST_POLY = 16'h0000;
    localparam logic [15:0] RST_TRANS_CONST = 16'h0034;
    localparam logic [15:0] RST_TRANS_SLOPE = 16'h0000;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [15:0] scale;
        logic [15:0] offset_linear;
        logic [15:0] offset_quadratic;
        logic [15:0] drift_constant;
        logic [15:0] drift_linear;
        logic [15:0] drift_quadratic;
        logic [15:0] polynomial;
        logic [15:0] transient_constant;
        logic [15:0] transient_slope;
    } coeff_t;

    typedef struct packed {
        logic object_upper_flag;
        logic object_lower_flag;
        logic die_upper_flag;
        logic die_lower_flag;
    } flags_t;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [THR_W-1:0] thr_field(input logic [15:0] word);
        thr_field = word[THR_MSB:THR_LSB];
    endfunction

    function automatic logic [15:0] thr_view(input logic [15:0] word);
        thr_view = {word[THR_MSB:THR_LSB], 6'h00};
    endfunction

endpackage
`default_nettype wire

//--- design/limit_compare.sv
// signed window compare of a result against an upper and lower threshold field
`timescale 1ns/1ps
`default_nettype none
module limit_compare
    import limit_coeff_pkg::*;
(
    input wire logic [15:0] result,
    input wire logic [THR_W-1:0] upper_field,
    input wire logic [THR_W-1:0] lower_field,
    output logic above,
    output logic below
);

    logic signed [THR_W-1:0] result_s;
    logic signed [THR_W-1:0] upper_s;
    logic signed [THR_W-1:0] lower_s;

    // ****************************************
    // signed compare on aligned field
    // ****************************************
    always_comb begin
        result_s = $signed(thr_field(result));
        upper_s = $signed(upper_field);
        lower_s = $signed(lower_field);
        above = result_s > upper_s;
        below = result_s < lower_s;
    end

endmodule // limit_compare
`default_nettype wire

//--- design/limit_and_coeff_regs.sv
// threshold and calibration coefficient register bank with limit flags
`timescale 1ns/1ps
`default_nettype none
module limit_and_coeff_regs
    import limit_coeff_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_index,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_hit,
    input wire logic conv_valid,
    input wire logic [15:0] object_temperature,
    input wire logic [15:0] die_temperature,
    input wire logic comp_mode,
    input wire logic status_rd_clr,
    output coeff_t coeff,
    output flags_t limit_flags
);

    // ****************************************
    // storage
    // ****************************************
    logic [THR_W-1:0] obj_upper_reg;
    logic [THR_W-1:0] obj_lower_reg;
    logic [THR_W-1:0] die_upper_reg;
    logic [THR_W-1:0] die_lower_reg;
    coeff_t coeff_reg;
    flags_t flags_reg;
    flags_t flags_next;
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_hit_reg;
    logic rd_hit_next;
    logic obj_above;
    logic obj_below;
    logic die_above;
    logic die_below;

    // ****************************************
    // threshold registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            obj_upper_reg <= thr_field(RST_OBJ_UPPER);
            obj_lower_reg <= thr_field(RST_OBJ_LOWER);
        end else if (wr_en) begin
            if (reg_index == IDX_OBJ_UPPER) begin
                obj_upper_reg <= thr_field(wr_data);
            end
            if (reg_index == IDX_OBJ_LOWER) begin
                obj_lower_reg <= thr_field(wr_data);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            die_upper_reg <= thr_field(RST_DIE_UPPER);
            die_lower_reg <= thr_field(RST_DIE_LOWER);
        end else if (wr_en) begin
            if (reg_index == IDX_DIE_UPPER) begin
                die_upper_reg <= thr_field(wr_data);
            end
            if (reg_index == IDX_DIE_LOWER) begin
                die_lower_reg <= thr_field(wr_data);
            end
        end
    end

    // ****************************************
    // coefficient registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            coeff_reg.scale <= RST_SCALE;
            coeff_reg.offset_linear <= RST_OFS_LIN;
            coeff_reg.offset_quadratic <= RST_OFS_QUAD;
            coeff_reg.drift_constant <= RST_DRIFT_CONST;
            coeff_reg.drift_linear <= RST_DRIFT_LIN;
            coeff_reg.drift_quadratic <= RST_DRIFT_QUAD;
            coeff_reg.polynomial <= RST_POLY;
            coeff_reg.transient_constant <= RST_TRANS_CONST;
            coeff_reg.transient_slope <= RST_TRANS_SLOPE;
        end else if (wr_en) begin
            unique case (reg_index)
                IDX_SCALE: begin
                    coeff_reg.scale <= wr_data;
                end
                IDX_OFS_LIN: begin
                    coeff_reg.offset_linear <= wr_data;
                end
                IDX_OFS_QUAD: begin
                    coeff_reg.offset_quadratic <= wr_data;
                end
                IDX_DRIFT_CONST: begin
                    coeff_reg.drift_constant <= wr_data;
                end
                IDX_DRIFT_LIN: begin
                    coeff_reg.drift_linear <= wr_data;
                end
                IDX_DRIFT_QUAD: begin
                    coeff_reg.drift_quadratic <= wr_data;
                end
                IDX_POLY: begin
                    coeff_reg.polynomial <= wr_data & POLY_MASK;
                end
                IDX_TRANS_CONST: begin
                    coeff_reg.transient_constant <= wr_data;
                end
                IDX_TRANS_SLOPE: begin
                    coeff_reg.transient_slope <= wr_data;
                end
                default: begin
                end
            endcase
        end
    end

    // math engine sees the live register contents
    assign coeff = coeff_reg;

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        rd_data_next = 16'h0000;
        rd_hit_next = 1'b1;
        unique case (reg_index)
            IDX_OBJ_UPPER: begin
                rd_data_next = {obj_upper_reg, 6'h00};
            end
            IDX_OBJ_LOWER: begin
                rd_data_next = {obj_lower_reg, 6'h00};
            end
            IDX_DIE_UPPER: begin
                rd_data_next = {die_upper_reg, 6'h00};
            end
            IDX_DIE_LOWER: begin
                rd_data_next = {die_lower_reg, 6'h00};
            end
            IDX_SCALE: begin
                rd_data_next = coeff_reg.scale;
            end
            IDX_OFS_LIN: begin
                rd_data_next = coeff_reg.offset_linear;
            end
            IDX_OFS_QUAD: begin
                rd_data_next = coeff_reg.offset_quadratic;
            end
            IDX_DRIFT_CONST: begin
                rd_data_next = coeff_reg.drift_constant;
            end
            IDX_DRIFT_LIN: begin
                rd_data_next = coeff_reg.drift_linear;
            end
            IDX_DRIFT_QUAD: begin
                rd_data_next = coeff_reg.drift_quadratic;
            end
            IDX_POLY: begin
                rd_data_next = coeff_reg.polynomial;
            end
            IDX_TRANS_CONST: begin
                rd_data_next = coeff_reg.transient_constant;
            end
            IDX_TRANS_SLOPE: begin
                rd_data_next = coeff_reg.transient_slope;
            end
            default: begin
                rd_hit_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
            rd_hit_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
            if (rd_en) begin
                rd_data_reg <= rd_data_next;
                rd_hit_reg <= rd_hit_next;
            end
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_hit = rd_hit_reg;

    // ****************************************
    // comparators
    // ****************************************
    limit_compare obj_cmp (
        .result(object_temperature),
        .upper_field(obj_upper_reg),
        .lower_field(obj_lower_reg),
        .above(obj_above),
        .below(obj_below)
    );

    limit_compare die_cmp (
        .result(die_temperature),
        .upper_field(die_upper_reg),
        .lower_field(die_lower_reg),
        .above(die_above),
        .below(die_below)
    );

    // ****************************************
    // limit flags
    // ****************************************
    always_comb begin
        flags_next = flags_reg;
        if (comp_mode) begin
            if (conv_valid) begin
                if (obj_above) begin
                    flags_next.object_upper_flag = 1'b1;
                end else if (obj_below) begin
                    flags_next.object_upper_flag = 1'b0;
                end
                if (die_above) begin
                    flags_next.die_upper_flag = 1'b1;
                end else if (die_below) begin
                    flags_next.die_upper_flag = 1'b0;
                end
            end
            flags_next.object_lower_flag = 1'b0;
            flags_next.die_lower_flag = 1'b0;
        end else begin
            if (status_rd_clr) begin
                flags_next = '0;
            end
            if (conv_valid) begin
                flags_next.object_upper_flag = flags_next.object_upper_flag | obj_above;
                flags_next.object_lower_flag = flags_next.object_lower_flag | obj_below;
                flags_next.die_upper_flag = flags_next.die_upper_flag | die_above;
                flags_next.die_lower_flag = flags_next.die_lower_flag | die_below;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign limit_flags = flags_reg;

    // ****************************************
    // checks
    // ****************************************
    logic [15:0] wr_data_d1;
    logic [15:0] wr_data_d2;
    logic out_of_reset_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_data_d1 <= 16'h0000;
            wr_data_d2 <= 16'h0000;
            out_of_reset_reg <= 1'b0;
        end else begin
            wr_data_d1 <= wr_data;
            wr_data_d2 <= wr_data_d1;
            out_of_reset_reg <= 1'b1;
        end
    end

    sequence s_write_then_read(logic [7:0] idx);
        wr_en && reg_index == idx ##1 rd_en && !wr_en && reg_index == idx;
    endsequence

    a_thr_low_zero: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && !wr_en && reg_index >= IDX_OBJ_UPPER && reg_index <= IDX_DIE_LOWER
        |=> rd_valid && rd_data[5:0] == 6'h00)
        else $error("threshold low bits not zero");

    a_obj_up_back: assert property (@(posedge clk) disable iff (!resetn)
        s_write_then_read(IDX_OBJ_UPPER) |=> rd_data == thr_view(wr_data_d2))
        else $error("object upper readback wrong");

    a_die_up_back: assert property (@(posedge clk) disable iff (!resetn)
        s_write_then_read(IDX_DIE_UPPER) |=> rd_data == thr_view(wr_data_d2))
        else $error("die upper readback wrong");

    a_scale_back: assert property (@(posedge clk) disable iff (!resetn)
        s_write_then_read(IDX_SCALE) |=> rd_data == wr_data_d2)
        else $error("scale readback wrong");

    a_reset_thr_vals: assert property (@(posedge clk) disable iff (!resetn)
        !out_of_reset_reg |-> {obj_upper_reg, 6'h00} == RST_OBJ_UPPER
            && {obj_lower_reg, 6'h00} == RST_OBJ_LOWER
            && {die_upper_reg, 6'h00} == RST_DIE_UPPER
            && {die_lower_reg, 6'h00} == RST_DIE_LOWER)
        else $error("threshold reset value wrong");

    a_reset_coeffs: assert property (@(posedge clk) disable iff (!resetn)
        !out_of_reset_reg |-> coeff.scale == RST_SCALE && coeff.offset_linear == RST_OFS_LIN
            && coeff.offset_quadratic == RST_OFS_QUAD && coeff.drift_constant == RST_DRIFT_CONST)
        else $error("coefficient reset value wrong");

    a_coeff_drive: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && reg_index == IDX_OFS_LIN |=> coeff.offset_linear == wr_data_d1)
        else $error("coefficient output not updated");

    a_obj_up_flag: assert property (@(posedge clk) disable iff (!resetn)
        conv_valid && $signed(object_temperature[15:6]) > $signed(obj_upper_reg)
        |=> limit_flags.object_upper_flag)
        else $error("object upper flag missed");

    a_obj_low_flag: assert property (@(posedge clk) disable iff (!resetn)
        conv_valid && !comp_mode && $signed(object_temperature[15:6]) < $signed(obj_lower_reg)
        |=> limit_flags.object_lower_flag)
        else $error("object lower flag missed");

    a_obj_low_comp: assert property (@(posedge clk) disable iff (!resetn)
        comp_mode [*2] |-> !limit_flags.object_lower_flag && !limit_flags.die_lower_flag)
        else $error("lower flag set in comparator mode");

    a_die_up_flag: assert property (@(posedge clk) disable iff (!resetn)
        conv_valid && $signed(die_temperature[15:6]) > $signed(die_upper_reg)
        |=> limit_flags.die_upper_flag)
        else $error("die upper flag missed");

    a_die_low_flag: assert property (@(posedge clk) disable iff (!resetn)
        conv_valid && !comp_mode && $signed(die_temperature[15:6]) < $signed(die_lower_reg)
        |=> limit_flags.die_lower_flag)
        else $error("die lower flag missed");

    a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
        status_rd_clr && !comp_mode && !conv_valid |=> limit_flags == '0)
        else $error("flags not cleared by status read");

endmodule // limit_and_coeff_regs
`default_nettype wire

//--- dv/host_model.sv
// host controller model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module host_model
    import limit_coeff_pkg::*;
(
    input wire logic clk,
    output logic [7:0] reg_index,
    output logic wr_en,
    output logic [15:0] wr_data,
    output logic rd_en
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        reg_index = 8'hFF;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        rd_en = 1'b0;
    end

    // enables drop and data and index lines flip so no stale value survives
    task automatic release_bus();
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_data = ~wr_data;
        reg_index = ~reg_index;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] data);
        @(posedge clk);
        #1;
        reg_index = idx;
        wr_data = data;
        wr_en = 1'b1;
        @(posedge clk);
        #1;
        release_bus();
    endtask

    // write then read of one index on back-to-back edges
    task automatic wr_rd(input logic [7:0] idx, input logic [15:0] data);
        @(posedge clk);
        #1;
        reg_index = idx;
        wr_data = data;
        wr_en = 1'b1;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(posedge clk);
        #1;
        release_bus();
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        #1;
        reg_index = idx;
        rd_en = 1'b1;
        @(posedge clk);
        #1;
        release_bus();
    endtask

    // reprogram transient pair after an averaging change
    task automatic set_transient(input logic [15:0] c0, input logic [15:0] c1);
        wr(IDX_TRANS_CONST, c0);
        wr(IDX_TRANS_SLOPE, c1);
    endtask
endmodule // host_model
`default_nettype wire

//--- dv/testbench.sv
// self-checking testbench for the limit and coefficient register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import limit_coeff_pkg::*;
();
    typedef struct packed {
        logic hit;
        logic [15:0] data;
    } rd_note_t;

    logic clk;
    logic resetn;
    logic [7:0] reg_index;
    logic wr_en;
    logic [15:0] wr_data;
    logic rd_en;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_hit;
    logic conv_valid;
    logic [15:0] object_temperature;
    logic [15:0] die_temperature;
    logic comp_mode;
    logic status_rd_clr;
    coeff_t coeff;
    flags_t limit_flags;
    logic [15:0] sh [0:255];
    logic [15:0] rst_tab [0:12] = '{RST_OBJ_UPPER, RST_OBJ_LOWER, RST_DIE_UPPER, RST_DIE_LOWER, RST_SCALE,
        RST_OFS_LIN, RST_OFS_QUAD, RST_DRIFT_CONST, RST_DRIFT_LIN, RST_DRIFT_QUAD, RST_POLY,
        RST_TRANS_CONST, RST_TRANS_SLOPE};
    rd_note_t notes [$];
    rd_note_t note;
    flags_t exp_flags;
    int mismatches;
    int total_checks;
    logic [15:0] seed;

    host_model u_host_model (.clk(clk), .reg_index(reg_index), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));

    limit_and_coeff_regs u_limit_and_coeff_regs (.clk(clk), .resetn(resetn), .reg_index(reg_index),
        .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_hit(rd_hit), .conv_valid(conv_valid), .object_temperature(object_temperature),
        .die_temperature(die_temperature), .comp_mode(comp_mode), .status_rd_clr(status_rd_clr),
        .coeff(coeff), .limit_flags(limit_flags));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= IDX_OBJ_UPPER) && (idx <= IDX_TRANS_SLOPE);
    endfunction

    function automatic logic [15:0] wmask(input logic [7:0] idx);
        if (idx >= IDX_OBJ_UPPER && idx <= IDX_DIE_LOWER) wmask = 16'hFFC0;
        else if (idx == IDX_POLY) wmask = POLY_MASK;
        else wmask = 16'hFFFF;
    endfunction

    // next flag state from one cycle of conversion inputs
    function automatic flags_t nxt(input flags_t f, input logic c, input logic k, input logic m,
        input logic [15:0] o, input logic [15:0] d);
        logic oa, ob, da, db;
        oa = $signed(o[15:6]) > $signed(sh[IDX_OBJ_UPPER][15:6]);
        ob = $signed(o[15:6]) < $signed(sh[IDX_OBJ_LOWER][15:6]);
        da = $signed(d[15:6]) > $signed(sh[IDX_DIE_UPPER][15:6]);
        db = $signed(d[15:6]) < $signed(sh[IDX_DIE_LOWER][15:6]);
        nxt = f;
        if (!m) begin
            nxt.object_upper_flag = (c && oa) || (f.object_upper_flag && !k);
            nxt.object_lower_flag = (c && ob) || (f.object_lower_flag && !k);
            nxt.die_upper_flag = (c && da) || (f.die_upper_flag && !k);
            nxt.die_lower_flag = (c && db) || (f.die_lower_flag && !k);
        end else begin
            nxt.object_lower_flag = 1'b0;
            nxt.die_lower_flag = 1'b0;
            if (c) nxt.object_upper_flag = oa ? 1'b1 : (ob ? 1'b0 : f.object_upper_flag);
            if (c) nxt.die_upper_flag = da ? 1'b1 : (db ? 1'b0 : f.die_upper_flag);
        end
    endfunction

    task automatic check(input logic ok, input string what);
        total_checks++;
        if (!ok) begin
            mismatches++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    task automatic end_of_test();
        check(notes.size() == 0, "reads left unanswered");
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // stimulus tasks
    // ****************************************
    task automatic do_reset();
        @(posedge clk);
        #1;
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        foreach (sh[i]) sh[i] = 16'h0000;
        for (int i = 0; i < 13; i++) sh[IDX_OBJ_UPPER + i] = rst_tab[i];
        exp_flags = '0;
    endtask

    task automatic do_wr(input logic [7:0] idx, input logic [15:0] d);
        if (mapped(idx)) sh[idx] = d & wmask(idx);
        u_host_model.wr(idx, d);
    endtask

    task automatic do_rd(input logic [7:0] idx);
        notes.push_back({mapped(idx), sh[idx]});
        u_host_model.rd(idx);
    endtask

    task automatic do_wr_rd(input logic [7:0] idx, input logic [15:0] d);
        if (mapped(idx)) sh[idx] = d & wmask(idx);
        notes.push_back({mapped(idx), sh[idx]});
        u_host_model.wr_rd(idx, d);
    endtask

    task automatic read_all();
        for (int i = 5; i <= 8'h13; i++) do_rd(8'(i));
        do_rd(8'hFF);
    endtask

    task automatic check_coeff();
        for (int i = 0; i < 9; i++) check(coeff[143 - 16 * i -: 16] === sh[IDX_SCALE + i], "coefficient output");
    endtask

    // random conversions; first cycle clears latched flags in latched mode
    task automatic run_flags(input logic mode, input int n);
        logic [15:0] r;
        @(posedge clk);
        #1;
        for (int k = 0; k < n; k++) begin
            seed = lfsr(seed);
            r = seed;
            seed = lfsr(seed);
            comp_mode = (k == 0) ? 1'b0 : mode;
            conv_valid = (k == 0) ? 1'b0 : (seed[0] | seed[1]);
            status_rd_clr = (k == 0) ? 1'b1 : (seed[2] & seed[3]);
            object_temperature = {{8{r[7]}}, r[7:0]};
            die_temperature = {{8{r[15]}}, r[15:8]};
            exp_flags = nxt(exp_flags, conv_valid, status_rd_clr, comp_mode, object_temperature, die_temperature);
            @(posedge clk);
            #1;
            check(limit_flags === exp_flags, "limit flags");
        end
        conv_valid = 1'b0;
        status_rd_clr = 1'b0;
    endtask

    // ****************************************
    // read monitor
    // ****************************************
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (notes.size() == 0) begin
                check(1'b0, "unexpected read data");
            end else begin
                note = notes.pop_front();
                check({rd_hit, rd_data} === note, "read data");
            end
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        conv_valid = 1'b0;
        object_temperature = 16'h0000;
        die_temperature = 16'h0000;
        comp_mode = 1'b0;
        status_rd_clr = 1'b0;
        mismatches = 0;
        total_checks = 0;
        seed = 16'h97EF;
        do_reset();
        check_coeff();
        read_all();
        for (int i = 5; i <= 8'h13; i++) begin
            seed = lfsr(seed);
            do_wr(8'(i), seed);
        end
        read_all();
        check_coeff();
        seed = lfsr(seed);
        do_wr_rd(IDX_OBJ_UPPER, seed);
        seed = lfsr(seed);
        do_wr_rd(IDX_DIE_UPPER, seed);
        seed = lfsr(seed);
        do_wr_rd(IDX_SCALE, seed);
        do_wr(IDX_OBJ_UPPER, 16'h003F);
        do_wr(IDX_OBJ_LOWER, 16'hFFC0);
        do_wr(IDX_DIE_UPPER, 16'h0000);
        do_wr(IDX_DIE_LOWER, 16'h0015);
        run_flags(1'b0, 200);
        run_flags(1'b1, 200);
        sh[IDX_TRANS_CONST] = 16'h1234;
        sh[IDX_TRANS_SLOPE] = 16'hFEDC;
        u_host_model.set_transient(16'h1234, 16'hFEDC);
        check_coeff();
        do_reset();
        read_all();
        check_coeff();
        repeat (3) @(posedge clk);
        end_of_test();
    end

    initial begin
        #100000;
        check(1'b0, "watchdog expired");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
